// ===== ccss_sequencer.sv
// cpu clock state sequencer with apb register file and glitch-free source switch
//
// Operation
// - after reset cpu runs on internal oscillator
// - halt gives one halt state per source
// - stop only from internal or main run
// - reset processing delay before internal run
// - stop, source, cpu, sub select placement
// - internal osc register: status and stop
// - gain set with main pins selected in the same write halts cpu clock briefly
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ccss_sequencer
    import ccss_pkg::*;
(
    input  wire logic        pclk,            // apb clock, 100 MHz
    input  wire logic        presetn,         // async reset, active low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb access phase
    input  wire logic        pwrite,          // apb direction
    input  wire logic [7:0]  paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    input  wire logic        stab_done,       // stabilization counter reached
    input  wire logic        ext_main_edge,   // one pulse per external main clock edge
    input  wire logic        hs_osc_running,  // internal oscillator is oscillating
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error on unmapped address
    output logic             cpu_clk_gate,    // cpu clock enabled
    output logic      [1:0]  cpu_src,         // source currently driving the cpu
    output logic             main_osc_en,     // main oscillator / input enabled
    output logic             sub_osc_en,      // subsystem oscillator / input enabled
    output logic             hs_osc_en,       // internal oscillator enabled
    output logic      [3:0]  cpu_state        // sequencer state
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  osc_mode_select_reg;   // field holder
    logic [7:0]  main_osc_control_reg;  // main oscillator stop
    logic [7:0]  main_clock_mode_reg;   // source and cpu select
    logic [7:0]  processor_clock_reg;   // cpu sub select
    logic [7:0]  internal_osc_mode_reg; // hs osc stop
    ccss_state_e state;                 // sequencer state
    logic [CNT_W-1:0] por_cnt;          // reset processing count
    logic [CNT_W-1:0] hold_cnt;         // cpu clock hold count
    logic [1:0]  mux_cnt;               // handover cycles left
    ccss_src_e   cur_src;               // source in use

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    ccss_apb_req_s req;
    assign req = '{psel, penable, pwrite, paddr, pwdata};
    wire access   = req.sel && req.enable;
    wire wr       = access && req.write;
    wire hit_osc  = req.addr == ADDR_OSC_MODE_SELECT;
    wire hit_moc  = req.addr == ADDR_MAIN_OSC_CTRL;
    wire hit_mcm  = req.addr == ADDR_MAIN_CLK_MODE;
    wire hit_pcc  = req.addr == ADDR_PROC_CLK;
    wire hit_rcm  = req.addr == ADDR_INT_OSC_MODE;
    wire hit_sts  = req.addr == ADDR_STATUS;
    wire hit_cmd  = req.addr == ADDR_COMMAND;
    wire mapped   = hit_osc | hit_moc | hit_mcm | hit_pcc | hit_rcm | hit_sts | hit_cmd;

    // field views
    wire amp_gain_select    = osc_mode_select_reg[BIT_AMP_GAIN];
    wire ext_main_input_sel = osc_mode_select_reg[BIT_EXT_MAIN_INPUT];
    wire main_pin_osc_sel   = osc_mode_select_reg[BIT_MAIN_PIN_OSC];
    wire ext_sub_input_sel  = osc_mode_select_reg[BIT_EXT_SUB_INPUT];
    wire sub_pin_osc_sel    = osc_mode_select_reg[BIT_SUB_PIN_OSC];
    wire main_osc_stop      = main_osc_control_reg[BIT_MAIN_OSC_STOP];
    wire main_source_sel    = main_clock_mode_reg[BIT_MAIN_SOURCE];
    wire main_cpu_clk_sel   = main_clock_mode_reg[BIT_MAIN_CPU];
    wire cpu_sub_clk_sel    = processor_clock_reg[BIT_CPU_SUB];
    wire hs_osc_stop_ctl    = internal_osc_mode_reg[BIT_HS_OSC_STOP];
    wire hs_osc_status_flag = hs_osc_running;

    // commands from the cpu core (halt/stop instructions, wake events)
    wire cmd_halt = wr && hit_cmd && req.wdata[BIT_CMD_HALT];
    wire cmd_stop = wr && hit_cmd && req.wdata[BIT_CMD_STOP];
    wire cmd_wake = wr && hit_cmd && req.wdata[BIT_CMD_WAKE];

    // gain rising with main pins in use starts the cpu clock hold
    wire amp_rise = wr && hit_osc && req.wdata[BIT_AMP_GAIN] && !amp_gain_select
                    && req.wdata[BIT_MAIN_PIN_OSC];
    wire amp_ext  = req.wdata[BIT_EXT_MAIN_INPUT];

    // wanted source, as the field table selects it; the counter status is
    // software's to check, so the selects are trusted as written
    wire want_main = main_source_sel && main_cpu_clk_sel && !cpu_sub_clk_sel;
    wire want_sub  = cpu_sub_clk_sel && sub_pin_osc_sel;
    wire ccss_src_e want_src = want_sub  ? CCSS_SRC_SUB  :
                               want_main ? CCSS_SRC_MAIN : CCSS_SRC_INT;

    // read mux; reserved bits read zero
    wire [7:0] sts_byte = {4'h0, state};
    wire [7:0] rcm_byte = {hs_osc_status_flag, 6'h00, hs_osc_stop_ctl};
    wire [7:0] rd_byte  = hit_osc ? osc_mode_select_reg  :
                          hit_moc ? main_osc_control_reg :
                          hit_mcm ? main_clock_mode_reg  :
                          hit_pcc ? processor_clock_reg  :
                          hit_rcm ? rcm_byte             :
                          hit_sts ? sts_byte             : 8'h00;

    // ------------------------------------------------------------------
    // apb response: zero wait states
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= req.sel && !req.enable;
            pslverr <= req.sel && !req.enable && !mapped;
            prdata  <= (req.sel && !req.enable && !req.write) ? {24'h000000, rd_byte} : 32'h0;
        end
    end
    wire done_wr = wr && pready; // write takes effect in the ready cycle

    // ------------------------------------------------------------------
    // register writes (only legal fields are kept)
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_mode_select_reg   <= RST_OSC_MODE_SELECT;
            main_osc_control_reg  <= RST_MAIN_OSC_CTRL;
            main_clock_mode_reg   <= RST_MAIN_CLK_MODE;
            processor_clock_reg   <= RST_PROC_CLK;
            internal_osc_mode_reg <= RST_INT_OSC_MODE;
        end else if (done_wr) begin
            if (hit_osc) osc_mode_select_reg   <= req.wdata[7:0] & 8'hF1;
            if (hit_moc) main_osc_control_reg  <= req.wdata[7:0] & 8'h80;
            if (hit_mcm) main_clock_mode_reg   <= req.wdata[7:0] & 8'h05;
            if (hit_pcc) processor_clock_reg   <= req.wdata[7:0] & 8'h10;
            if (hit_rcm) internal_osc_mode_reg <= req.wdata[7:0] & 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------------
    ccss_state_e next_state;
    wire por_done = por_cnt == CNT_W'(POR_CYCLES);
    always_comb begin
        next_state = state;
        case (state)
            CCSS_RESET:     if (por_done) next_state = CCSS_INT_RUN;
            CCSS_INT_RUN,
            CCSS_MAIN_RUN,
            CCSS_SUB_RUN: begin
                if (done_wr && cmd_halt) begin
                    next_state = (cur_src == CCSS_SRC_SUB)  ? CCSS_SUB_HALT  :
                                 (cur_src == CCSS_SRC_MAIN) ? CCSS_MAIN_HALT : CCSS_INT_HALT;
                end else if (done_wr && cmd_stop && cur_src != CCSS_SRC_SUB) begin
                    next_state = (cur_src == CCSS_SRC_MAIN) ? CCSS_MAIN_STOP : CCSS_INT_STOP;
                end else begin
                    next_state = (cur_src == CCSS_SRC_SUB)  ? CCSS_SUB_RUN  :
                                 (cur_src == CCSS_SRC_MAIN) ? CCSS_MAIN_RUN : CCSS_INT_RUN;
                end
            end
            CCSS_INT_HALT,
            CCSS_INT_STOP:  if (done_wr && cmd_wake) next_state = CCSS_INT_RUN;
            CCSS_MAIN_HALT,
            CCSS_MAIN_STOP: if (done_wr && cmd_wake) next_state = CCSS_MAIN_RUN;
            CCSS_SUB_HALT:  if (done_wr && cmd_wake) next_state = CCSS_SUB_RUN;
            default:        next_state = CCSS_RESET;
        endcase
    end
    wire running = state == CCSS_INT_RUN || state == CCSS_MAIN_RUN || state == CCSS_SUB_RUN;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= CCSS_RESET;
            por_cnt <= '0;
        end else begin
            state   <= next_state;
            if (state == CCSS_RESET && !por_done) por_cnt <= por_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // cpu clock hold after gain set; counts pclk for crystal and
    // external edges for an external main clock
    // ------------------------------------------------------------------
    logic hold_ext;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= '0;
            hold_ext <= 1'b0;
        end else if (done_wr && amp_rise) begin
            hold_cnt <= amp_ext ? CNT_W'(EXT_HOLD_EDGES) : CNT_W'(AMP_HOLD_CYCLES);
            hold_ext <= amp_ext;
        end else if (hold_cnt != '0 && (!hold_ext || ext_main_edge)) begin
            hold_cnt <= hold_cnt - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // glitch-free handover: gate off, settle on the old side, switch, settle on the new side, gate on
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur_src <= CCSS_SRC_INT;
            mux_cnt <= '0;
        end else if (!running) begin
            mux_cnt <= '0;
        end else if (mux_cnt == 2'd1) begin
            cur_src <= want_src;
            mux_cnt <= '0;
        end else if (mux_cnt != '0) begin
            mux_cnt <= mux_cnt - 1'b1;
        end else if (want_src != cur_src) begin
            mux_cnt <= 2'(MUX_SYNC_CYCLES + 1);
        end
    end

    // ------------------------------------------------------------------
    // outputs from flip-flops
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_gate <= 1'b0;
            cpu_src      <= 2'h0;
            main_osc_en  <= 1'b0;
            sub_osc_en   <= 1'b0;
            hs_osc_en    <= 1'b1;
            cpu_state    <= 4'h0;
        end else begin
            // one settle cycle on the new source before the gate reopens
            cpu_clk_gate <= (next_state == CCSS_INT_RUN || next_state == CCSS_MAIN_RUN ||
                             next_state == CCSS_SUB_RUN) && mux_cnt == '0 && hold_cnt == '0
                            && cpu_src == cur_src;
            cpu_src      <= cur_src;
            main_osc_en  <= main_pin_osc_sel && !main_osc_stop && state != CCSS_MAIN_STOP
                            && state != CCSS_INT_STOP;
            sub_osc_en   <= sub_pin_osc_sel;  // sub clock keeps running through stop
            hs_osc_en    <= !(hs_osc_stop_ctl && cur_src != CCSS_SRC_INT) && state != CCSS_INT_STOP
                            && state != CCSS_MAIN_STOP;
            cpu_state    <= next_state;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    por_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state == CCSS_INT_RUN) && $past(state) == CCSS_RESET |-> por_cnt == CNT_W'(POR_CYCLES))
        else $error("left reset before processing delay");
    reset_src_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(state) == CCSS_RESET && state == CCSS_INT_RUN |-> cur_src == CCSS_SRC_INT)
        else $error("first run state not on internal oscillator");
    halt_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == CCSS_MAIN_RUN && done_wr && cmd_halt |=> state == CCSS_MAIN_HALT)
        else $error("halt from main run went wrong");
    stop_sub_a: assert property (@(posedge pclk) disable iff (!presetn)
        state == CCSS_SUB_RUN && done_wr && cmd_stop && !cmd_halt |=> state == CCSS_SUB_RUN)
        else $error("stop taken from subsystem clock");
    hold_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_wr && amp_rise && !amp_ext |=> hold_cnt == CNT_W'(AMP_HOLD_CYCLES) ##1 !cpu_clk_gate)
        else $error("crystal gain hold not started");
    ext_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        done_wr && amp_rise && amp_ext |=> hold_cnt == CNT_W'(EXT_HOLD_EDGES))
        else $error("external gain hold not 160 edges");
    mux_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(cur_src) |-> !cpu_clk_gate ##1 !cpu_clk_gate)
        else $error("cpu clock running across source change");
    mode_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
        (osc_mode_select_reg & 8'h0E) == 8'h00 && (main_clock_mode_reg & 8'hFA) == 8'h00)
        else $error("reserved field bits set");
    hs_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        hit_rcm && req.sel && !req.enable && !req.write |=> prdata[7] == $past(hs_osc_running))
        else $error("status flag not at bit 7");
    main_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
        running && mux_cnt == '0 && want_src == CCSS_SRC_MAIN && cur_src != CCSS_SRC_MAIN
        |-> ##[1:4] cur_src == CCSS_SRC_MAIN)
        else $error("main select not honoured");

    cov_main_c: cover property (@(posedge pclk) disable iff (!presetn) state == CCSS_MAIN_RUN);
    cov_sub_c:  cover property (@(posedge pclk) disable iff (!presetn) state == CCSS_SUB_HALT);
    cov_stop_c: cover property (@(posedge pclk) disable iff (!presetn) state == CCSS_INT_STOP);
    cov_hold_c: cover property (@(posedge pclk) disable iff (!presetn) hold_cnt == CNT_W'(1));

endmodule : ccss_sequencer
`default_nettype wire

// ===== ccss_pkg.sv
// package for the cpu clock state sequencer: register map, fields, states, timing
package ccss_pkg;

    // ------------------------------------------------------------------
    // register byte addresses (apb, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_OSC_MODE_SELECT = 8'h00; // osc_mode_select_reg
    localparam logic [7:0] ADDR_MAIN_OSC_CTRL   = 8'h04; // main_osc_control_reg
    localparam logic [7:0] ADDR_MAIN_CLK_MODE   = 8'h08; // main_clock_mode_reg
    localparam logic [7:0] ADDR_PROC_CLK        = 8'h0C; // processor_clock_reg
    localparam logic [7:0] ADDR_INT_OSC_MODE    = 8'h10; // internal_osc_mode_reg
    localparam logic [7:0] ADDR_STATUS          = 8'h14; // sequencer state, read only
    localparam logic [7:0] ADDR_COMMAND         = 8'h18; // halt / stop / wake strobes

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_EXT_MAIN_INPUT = 7;  // osc mode select
    localparam int BIT_MAIN_PIN_OSC   = 6;
    localparam int BIT_EXT_SUB_INPUT  = 5;
    localparam int BIT_SUB_PIN_OSC    = 4;
    localparam int BIT_AMP_GAIN       = 0;
    localparam int BIT_MAIN_OSC_STOP  = 7;  // main osc control
    localparam int BIT_MAIN_SOURCE    = 2;  // main clock mode
    localparam int BIT_MAIN_CPU       = 0;
    localparam int BIT_CPU_SUB        = 4;  // processor clock
    localparam int BIT_HS_OSC_STATUS  = 7;  // internal osc mode
    localparam int BIT_HS_OSC_STOP    = 0;
    localparam int BIT_CMD_HALT       = 0;  // command strobes
    localparam int BIT_CMD_STOP       = 1;
    localparam int BIT_CMD_WAKE       = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_OSC_MODE_SELECT = 8'h00;
    localparam logic [7:0] RST_MAIN_OSC_CTRL   = 8'h80; // main oscillator stopped
    localparam logic [7:0] RST_MAIN_CLK_MODE   = 8'h00;
    localparam logic [7:0] RST_PROC_CLK        = 8'h00;
    localparam logic [7:0] RST_INT_OSC_MODE    = 8'h00;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS      = 10000;  // 100 MHz
    localparam int POR_MIN_NS         = 11000;  // reset processing, least
    localparam int POR_MAX_NS         = 45000;  // reset processing, longest
    localparam int POR_CYCLES         = (POR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int AMP_HOLD_MIN_PS    = 4060000;  // cpu clock hold, crystal, least
    localparam int AMP_HOLD_MAX_PS    = 16120000; // cpu clock hold, crystal, longest
    localparam int AMP_HOLD_CYCLES    = (AMP_HOLD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int EXT_HOLD_EDGES     = 160;    // external clock edges of hold
    localparam int MUX_SYNC_CYCLES    = 2;      // glitch-free handover settle before the switch, old side only
    localparam int CNT_W              = 16;

    // ------------------------------------------------------------------
    // states, gray along reset -> internal -> main -> sub
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CCSS_RESET     = 4'h0,
        CCSS_INT_RUN   = 4'h1,
        CCSS_MAIN_RUN  = 4'h3,
        CCSS_SUB_RUN   = 4'h2,
        CCSS_INT_HALT  = 4'h6,
        CCSS_MAIN_HALT = 4'h7,
        CCSS_SUB_HALT  = 4'h5,
        CCSS_INT_STOP  = 4'h4,
        CCSS_MAIN_STOP = 4'hC
    } ccss_state_e;

    // cpu clock source codes
    typedef enum logic [1:0] {
        CCSS_SRC_INT  = 2'h0,
        CCSS_SRC_MAIN = 2'h1,
        CCSS_SRC_SUB  = 2'h2
    } ccss_src_e;

    // apb request carrier
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } ccss_apb_req_s;

endpackage : ccss_pkg

// ===== test_cpu_clock_state_sequencer.sv
// self-checking apb testbench for the cpu clock state sequencer
`timescale 1ns/1ps
`default_nettype none
module test_cpu_clock_state_sequencer;
    import ccss_pkg::*;
    // ------------------------------------------------------------------
    // stimulus, observed outputs and counters
    // ------------------------------------------------------------------
    logic        pclk = 1'b0, presetn = 1'b0;   // clock and active low reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;                 // apb byte address
    logic [31:0] pwdata = 32'h0, prdata, q;     // q holds last read data
    logic        pready, pslverr, perr;         // perr holds last error flag
    logic        ext_main_edge = 1'b0, hs_osc_running = 1'b1;
    logic        cpu_clk_gate, main_osc_en, sub_osc_en, hs_osc_en;
    logic [1:0]  cpu_src;
    logic [3:0]  cpu_state;
    int          fails = 0, total_checks = 0, cyc = 0;

    ccss_sequencer i_ccss_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .stab_done(1'b0), .ext_main_edge(ext_main_edge), .hs_osc_running(hs_osc_running),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_clk_gate(cpu_clk_gate),
        .cpu_src(cpu_src), .main_osc_en(main_osc_en), .sub_osc_en(sub_osc_en),
        .hs_osc_en(hs_osc_en), .cpu_state(cpu_state));

    // free running clock; the timeout guards every unbounded wait
    initial begin
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer: setup, access held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("prdata", e, q);
    endtask : rd
    // a command write lands in one edge; state is looked at once settled
    task automatic cmd(input int b, input logic [3:0] e);
        apb(1'b1, ADDR_COMMAND, 32'h1 << b);
        @(posedge pclk); #1;
        chk("cpu_state", {28'h0, e}, {28'h0, cpu_state});
    endtask : cmd
    // source handover takes a few cycles; wait bounded, then compare
    task automatic wsrc(input logic [1:0] e, input logic [3:0] s);
        for (int i = 0; i < 20 && cpu_src !== e; i++) @(posedge pclk);
        repeat (2) @(posedge pclk); #1;
        chk("cpu_src", {30'h0, e}, {30'h0, cpu_src});
        chk("cpu_state", {28'h0, s}, {28'h0, cpu_state});
    endtask : wsrc

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (POR_CYCLES - 1) @(posedge pclk); #1;
        chk("cpu_state", {28'h0, CCSS_RESET}, {28'h0, cpu_state});
        repeat (2) @(posedge pclk); #1;
        chk("cpu_state", {28'h0, CCSS_INT_RUN}, {28'h0, cpu_state});
        wsrc(CCSS_SRC_INT, CCSS_INT_RUN);
        chk("osc_en", 32'h1, {29'h0, main_osc_en, sub_osc_en, hs_osc_en});
        rd(ADDR_OSC_MODE_SELECT, 32'h0);
        rd(ADDR_MAIN_OSC_CTRL, 32'h80);
        rd(ADDR_INT_OSC_MODE, 32'h80);
        hs_osc_running <= 1'b0;
        rd(ADDR_INT_OSC_MODE, 32'h0);
        rd(8'h1C, 32'h0);
        chk("pslverr", 32'h1, {31'h0, perr});
        cmd(BIT_CMD_HALT, CCSS_INT_HALT);
        cmd(BIT_CMD_WAKE, CCSS_INT_RUN);
        cmd(BIT_CMD_STOP, CCSS_INT_STOP);
        cmd(BIT_CMD_WAKE, CCSS_INT_RUN);
        // external main clock below 10 MHz, no counter check
        apb(1'b1, ADDR_OSC_MODE_SELECT, 32'hC0);
        apb(1'b1, ADDR_MAIN_OSC_CTRL, 32'h00);
        apb(1'b1, ADDR_MAIN_CLK_MODE, 32'h05);
        wsrc(CCSS_SRC_MAIN, CCSS_MAIN_RUN);
        chk("osc_en", 32'h5, {29'h0, main_osc_en, sub_osc_en, hs_osc_en});
        rd(ADDR_OSC_MODE_SELECT, 32'hC0);
        cmd(BIT_CMD_HALT, CCSS_MAIN_HALT);
        cmd(BIT_CMD_WAKE, CCSS_MAIN_RUN);
        cmd(BIT_CMD_STOP, CCSS_MAIN_STOP);
        chk("osc_en", 32'h0, {29'h0, main_osc_en, sub_osc_en, hs_osc_en});
        cmd(BIT_CMD_WAKE, CCSS_MAIN_RUN);
        // external subsystem clock, selected without a wait
        apb(1'b1, ADDR_OSC_MODE_SELECT, 32'hF0);
        apb(1'b1, ADDR_PROC_CLK, 32'h10);
        wsrc(CCSS_SRC_SUB, CCSS_SUB_RUN);
        chk("osc_en", 32'h7, {29'h0, main_osc_en, sub_osc_en, hs_osc_en});
        cmd(BIT_CMD_HALT, CCSS_SUB_HALT);
        cmd(BIT_CMD_WAKE, CCSS_SUB_RUN);
        cmd(BIT_CMD_STOP, CCSS_SUB_RUN);
        apb(1'b1, ADDR_PROC_CLK, 32'h00);
        wsrc(CCSS_SRC_MAIN, CCSS_MAIN_RUN);
        // raising gain on external main holds the cpu clock for 160 edges
        apb(1'b1, ADDR_OSC_MODE_SELECT, 32'hF1);
        repeat (2) @(posedge pclk); #1;
        chk("cpu_clk_gate", 32'h0, {31'h0, cpu_clk_gate});
        ext_main_edge <= 1'b1;
        repeat (EXT_HOLD_EDGES) @(posedge pclk); #1;
        chk("cpu_clk_gate", 32'h0, {31'h0, cpu_clk_gate});
        ext_main_edge <= 1'b0;
        @(posedge pclk); #1;
        chk("cpu_clk_gate", 32'h1, {31'h0, cpu_clk_gate});
        // crystal main pins, then gain raised: hold counted in pclk cycles
        apb(1'b1, ADDR_OSC_MODE_SELECT, 32'h70);
        apb(1'b1, ADDR_OSC_MODE_SELECT, 32'h71);
        repeat (AMP_HOLD_CYCLES) @(posedge pclk); #1;
        chk("cpu_clk_gate", 32'h0, {31'h0, cpu_clk_gate});
        @(posedge pclk); #1;
        chk("cpu_clk_gate", 32'h1, {31'h0, cpu_clk_gate});
        // subsystem crystal: pins set, stabilization wait, then select
        apb(1'b1, ADDR_OSC_MODE_SELECT, 32'h51);
        repeat (20) @(posedge pclk);
        apb(1'b1, ADDR_PROC_CLK, 32'h10);
        wsrc(CCSS_SRC_SUB, CCSS_SUB_RUN);
        stop_test();
    end
endmodule : test_cpu_clock_state_sequencer
`default_nettype wire
